//--- timer_wave_output_control.sv
// Timer counter with compare channels and waveform output control.
// Assumes timer_tick is a single-cycle enable from a prescaler on clk.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module timer_wave_output_control #(
  parameter int ADDR_W = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic timer_tick,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic out_a_connect,
  output logic out_b_connect
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(timer_wave_pkg::ADDR_CTRL_A) || a == ADDR_W'(timer_wave_pkg::ADDR_CTRL_B)
      || a == ADDR_W'(timer_wave_pkg::ADDR_CMP_A) || a == ADDR_W'(timer_wave_pkg::ADDR_CMP_B)
      || a == ADDR_W'(timer_wave_pkg::ADDR_COUNT) || a == ADDR_W'(timer_wave_pkg::ADDR_STATUS);
  endfunction

  // Action on one channel output for the current mode class
  function automatic logic [1:0] wave_action(
    input logic [1:0] com,
    input logic is_a,
    input logic high_bit,
    input logic non_pwm,
    input logic fast,
    input logic phase,
    input logic match,
    input logic up,
    input logic top_hit,
    input logic bottom_hit,
    input logic ocr_top
  );
    logic [1:0] act;
    act = timer_wave_pkg::ACT_NONE;
    if (non_pwm && match) // RULE18
    begin
      unique case (com) // RULE3 RULE4
        2'h1: act = timer_wave_pkg::ACT_TOGGLE;
        2'h2: act = timer_wave_pkg::ACT_CLEAR;
        2'h3: act = timer_wave_pkg::ACT_SET;
        default: act = timer_wave_pkg::ACT_NONE;
      endcase
    end
    else if ((fast || phase) && com == 2'h1)
    begin
      if (is_a && high_bit && match) // RULE6 RULE7 RULE9
        act = timer_wave_pkg::ACT_TOGGLE;
    end
    else if (fast && com[1])
    begin
      if (bottom_hit) // RULE5 RULE7 RULE10
        act = com[0] ? timer_wave_pkg::ACT_CLEAR : timer_wave_pkg::ACT_SET;
      else if (match && !ocr_top)
        act = com[0] ? timer_wave_pkg::ACT_SET : timer_wave_pkg::ACT_CLEAR;
    end
    else if (phase && com[1])
    begin
      if (ocr_top)
      begin
        if (top_hit) // RULE11
          act = com[0] ? timer_wave_pkg::ACT_CLEAR : timer_wave_pkg::ACT_SET;
      end
      else if (match) // RULE8 RULE9
        act = (com[0] ^ up) ? timer_wave_pkg::ACT_CLEAR : timer_wave_pkg::ACT_SET;
    end
    return act;
  endfunction

  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    return act == timer_wave_pkg::ACT_SET ? 1'b1 : act == timer_wave_pkg::ACT_CLEAR ? 1'b0
      : act == timer_wave_pkg::ACT_TOGGLE ? ~cur : cur;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0] ctrl_a, cmp_a_buf, cmp_b_buf, compare_value_a, compare_value_b, counter_value;
  logic mode_high, count_down, block_match, overflow_flag, ocf_a, ocf_b;
  logic [7:0] next_ctrl_a, next_cmp_a_buf, next_cmp_b_buf;
  logic [7:0] next_compare_value_a, next_compare_value_b, next_counter_value;
  logic [31:0] next_prdata;
  logic next_mode_high, next_pready, next_pslverr, next_count_down, next_block_match;
  logic next_overflow_flag, next_ocf_a, next_ocf_b, next_wave_out_a, next_wave_out_b;
  logic next_out_a_connect, next_out_b_connect;

  // ****************************************
  // Mode decode
  // ****************************************
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  logic [2:0] waveform_mode;
  logic non_pwm;
  logic fast;
  logic phase;
  logic immediate;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic wr;
  logic [7:0] wbyte;
  logic cnt_wr;
  logic match_a;
  logic match_b;
  logic wrap;
  logic top_turn;
  logic bottom_turn;

  assign chan_a_output_mode = ctrl_a[timer_wave_pkg::COM_A_LSB +: 2];
  assign chan_b_output_mode = ctrl_a[timer_wave_pkg::COM_B_LSB +: 2];
  assign waveform_mode = {mode_high, ctrl_a[timer_wave_pkg::MODE_LOW_LSB +: 2]}; // RULE13
  assign non_pwm = waveform_mode == timer_wave_pkg::MODE_NORMAL
    || waveform_mode == timer_wave_pkg::MODE_CLEAR_MATCH;
  assign fast = waveform_mode == timer_wave_pkg::MODE_FAST_FF
    || waveform_mode == timer_wave_pkg::MODE_FAST_A;
  assign phase = waveform_mode == timer_wave_pkg::MODE_PHASE_FF
    || waveform_mode == timer_wave_pkg::MODE_PHASE_A;
  assign immediate = non_pwm; // RULE14
  assign top = (waveform_mode == timer_wave_pkg::MODE_CLEAR_MATCH
    || waveform_mode == timer_wave_pkg::MODE_PHASE_A
    || waveform_mode == timer_wave_pkg::MODE_FAST_A) ? compare_value_a
    : timer_wave_pkg::COUNT_MAX; // RULE14 RULE15 RULE16 RULE17
  assign at_top = counter_value == top;
  assign at_bottom = counter_value == timer_wave_pkg::COUNT_BOTTOM; // RULE17
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign wbyte = pwdata[7:0];
  assign cnt_wr = wr && paddr == ADDR_W'(timer_wave_pkg::ADDR_COUNT);
  assign match_a = timer_tick && !block_match && counter_value == compare_value_a
    && (non_pwm || fast || phase);
  assign match_b = timer_tick && !block_match && counter_value == compare_value_b
    && (non_pwm || fast || phase);
  assign wrap = timer_tick && at_top && (fast || waveform_mode == timer_wave_pkg::MODE_CLEAR_MATCH);
  assign top_turn = timer_tick && phase && !count_down && at_top;
  assign bottom_turn = timer_tick && phase && count_down && at_bottom;

  // ****************************************
  // Register bus
  // ****************************************
  always_comb
  begin
    next_ctrl_a = ctrl_a;
    next_mode_high = mode_high;
    next_cmp_a_buf = cmp_a_buf;
    next_cmp_b_buf = cmp_b_buf;
    next_pready = psel && !penable && !pready;
    next_pslverr = psel && !penable && !pready && !known_addr(paddr);
    next_prdata = 32'h0;
    if (psel && !penable)
    begin
      if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CTRL_A))
        next_prdata = {24'h0, ctrl_a & timer_wave_pkg::CTRL_A_WMASK}; // RULE12
      else if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CTRL_B))
        next_prdata = 32'(mode_high) << timer_wave_pkg::MODE_HIGH_POS;
      else if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CMP_A))
        next_prdata = {24'h0, cmp_a_buf};
      else if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CMP_B))
        next_prdata = {24'h0, cmp_b_buf};
      else if (paddr == ADDR_W'(timer_wave_pkg::ADDR_COUNT))
        next_prdata = {24'h0, counter_value};
      else if (paddr == ADDR_W'(timer_wave_pkg::ADDR_STATUS))
        next_prdata = {28'h0, count_down, ocf_b, ocf_a, overflow_flag};
    end
    if (wr)
    begin
      if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CTRL_A))
        next_ctrl_a = wbyte & timer_wave_pkg::CTRL_A_WMASK; // RULE12
      if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CTRL_B))
        next_mode_high = wbyte[timer_wave_pkg::MODE_HIGH_POS];
      if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CMP_A))
        next_cmp_a_buf = wbyte;
      if (paddr == ADDR_W'(timer_wave_pkg::ADDR_CMP_B))
        next_cmp_b_buf = wbyte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_a <= timer_wave_pkg::CTRL_A_RESET;
      mode_high <= 1'b0;
      cmp_a_buf <= timer_wave_pkg::CMP_RESET;
      cmp_b_buf <= timer_wave_pkg::CMP_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl_a <= next_ctrl_a;
      mode_high <= next_mode_high;
      cmp_a_buf <= next_cmp_a_buf;
      cmp_b_buf <= next_cmp_b_buf;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Counter, flags and outputs
  // ****************************************
  always_comb
  begin
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_counter_value = counter_value;
    next_count_down = count_down;
    next_block_match = block_match && !timer_tick;
    next_overflow_flag = overflow_flag;
    next_ocf_a = ocf_a;
    next_ocf_b = ocf_b;
    if (immediate || (fast && wrap) || top_turn) // RULE14 RULE15 RULE16
    begin
      next_compare_value_a = next_cmp_a_buf;
      next_compare_value_b = next_cmp_b_buf;
    end
    if (timer_tick)
    begin
      if (non_pwm || fast) // RULE20
        next_counter_value = wrap ? timer_wave_pkg::COUNT_BOTTOM : counter_value + 8'h01;
      else if (phase) // RULE19
      begin
        if (!count_down && at_top && !at_bottom)
        begin
          next_count_down = 1'b1;
          next_counter_value = counter_value - 8'h01;
        end
        else if (count_down && at_bottom)
        begin
          next_count_down = 1'b0;
          next_counter_value = at_top ? counter_value : counter_value + 8'h01;
        end
        else if (!at_top || !at_bottom)
          next_counter_value = count_down ? counter_value - 8'h01 : counter_value + 8'h01;
      end
    end
    if (!phase)
      next_count_down = 1'b0;
    if (cnt_wr)
    begin
      next_counter_value = wbyte;
      next_block_match = 1'b1;
    end
    if (wr && paddr == ADDR_W'(timer_wave_pkg::ADDR_STATUS))
    begin
      next_overflow_flag = next_overflow_flag && !wbyte[timer_wave_pkg::OVF_POS];
      next_ocf_a = next_ocf_a && !wbyte[timer_wave_pkg::OCF_A_POS];
      next_ocf_b = next_ocf_b && !wbyte[timer_wave_pkg::OCF_B_POS];
    end
    // Hardware set wins over a same-cycle clear
    if ((timer_tick && (non_pwm || waveform_mode == timer_wave_pkg::MODE_FAST_FF)
        && counter_value == timer_wave_pkg::COUNT_MAX) // RULE14 RULE16 RULE17
      || (timer_tick && waveform_mode == timer_wave_pkg::MODE_FAST_A && at_top) // RULE16
      || bottom_turn) // RULE15
      next_overflow_flag = 1'b1;
    if (match_a)
      next_ocf_a = 1'b1;
    if (match_b)
      next_ocf_b = 1'b1;
    next_wave_out_a = apply_action(wave_action(chan_a_output_mode, 1'b1, mode_high, non_pwm,
      fast, phase, match_a, !count_down, top_turn, fast && wrap,
      compare_value_a == top), wave_out_a); // RULE21
    next_wave_out_b = apply_action(wave_action(chan_b_output_mode, 1'b0, mode_high, non_pwm,
      fast, phase, match_b, !count_down, top_turn, fast && wrap,
      compare_value_b == top), wave_out_b); // RULE21
    next_out_a_connect = chan_a_output_mode != 2'h0; // RULE1
    next_out_b_connect = chan_b_output_mode != 2'h0; // RULE1
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      compare_value_a <= timer_wave_pkg::CMP_RESET;
      compare_value_b <= timer_wave_pkg::CMP_RESET;
      counter_value <= timer_wave_pkg::COUNT_RESET;
      count_down <= 1'b0;
      block_match <= 1'b0;
      overflow_flag <= 1'b0;
      ocf_a <= 1'b0;
      ocf_b <= 1'b0;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      out_a_connect <= 1'b0;
      out_b_connect <= 1'b0;
    end
    else
    begin
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      counter_value <= next_counter_value;
      count_down <= next_count_down;
      block_match <= next_block_match;
      overflow_flag <= next_overflow_flag;
      ocf_a <= next_ocf_a;
      ocf_b <= next_ocf_b;
      wave_out_a <= next_wave_out_a;
      wave_out_b <= next_wave_out_b;
      out_a_connect <= next_out_a_connect;
      out_b_connect <= next_out_b_connect;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  reserved_bits_zero_a: assert property (pready && $past(psel && !penable) // RULE12
    && $past(paddr) == ADDR_W'(timer_wave_pkg::ADDR_CTRL_A) |-> prdata[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
  pin_a_connect_a: assert property (out_a_connect // RULE1
    == ($past(chan_a_output_mode) != 2'h0)) else $error("output a takeover wrong");
  pin_b_connect_a: assert property (out_b_connect // RULE1
    == ($past(chan_b_output_mode) != 2'h0)) else $error("output b takeover wrong");
  fast_wrap_a: assert property (fast && wrap && !cnt_wr |=> counter_value == 8'h00) // RULE20
    else $error("fast mode did not clear after top");
  phase_turn_a: assert property (top_turn && !cnt_wr && top != 8'h00 // RULE19
    |=> count_down && counter_value == $past(top) - 8'h01)
    else $error("phase mode did not turn at top");
  normal_toggle_a: assert property (non_pwm && chan_a_output_mode == 2'h1 && match_a // RULE3
    |=> wave_out_a != $past(wave_out_a)) else $error("output a did not toggle");
  normal_clear_b_a: assert property (non_pwm && chan_b_output_mode == 2'h2 && match_b // RULE4
    |=> !wave_out_b) else $error("output b not cleared on match");
  fast_bottom_set_a: assert property (fast && wrap && chan_a_output_mode == 2'h2 // RULE5
    |=> wave_out_a) else $error("output a not set at bottom");
  fast_top_flag_a: assert property (waveform_mode == 3'h7 && timer_tick && at_top // RULE16
    |=> overflow_flag) else $error("overflow not flagged at top");
  reserved_mode_hold_a: assert property ((waveform_mode == 3'h4 // RULE13
    || waveform_mode == 3'h6) && !cnt_wr |=> $stable(counter_value) && $stable(wave_out_a))
    else $error("reserved mode moved the counter");
  phase_buffer_load_a: assert property (top_turn && !wr // RULE15
    |=> compare_value_a == $past(cmp_a_buf)) else $error("buffer not loaded at top");
  fast_b_reserved_a: assert property (fast && chan_b_output_mode == 2'h1 // RULE7
    |=> $stable(wave_out_b)) else $error("reserved code moved output b");
  phase_up_clear_a: assert property (phase && chan_a_output_mode == 2'h2 && match_a // RULE8
    && !count_down && compare_value_a != top |=> !wave_out_a)
    else $error("output a not cleared on up match");
  tick_gated_a: assert property (!timer_tick // RULE21
    |=> $stable(wave_out_a) && $stable(wave_out_b)) else $error("output moved without a tick");

  fast_pwm_c: cover property (fast && wrap ##[1:600] fast && match_a);
  phase_cycle_c: cover property (top_turn ##[1:600] bottom_turn);
  overflow_clear_c: cover property (overflow_flag ##1 !overflow_flag);
  unmapped_c: cover property (pslverr && pready);
endmodule

//--- timer_wave_pkg.sv
// Constants for the timer waveform output control block.
// Assumes an APB master on the core clock and a timer tick from a prescaler.
// Behaviour
// RULE1: Nonzero output mode field hands pin to waveform
// RULE2: Software sets pin direction before enabling output
// RULE3: Non-PWM channel A: disconnect, toggle, clear, set
// RULE4: Non-PWM channel B codes match channel A
// RULE5: Fast PWM A: 10 non-inverting, 11 inverting
// RULE6: PWM A code 01 toggles only with high bit
// RULE7: Fast PWM B: 01 reserved, 10/11 as A
// RULE8: Phase correct A: clear up, set down, inverse
// RULE9: Phase correct B: 01 reserved, else as A
// RULE10: Fast PWM compare at TOP acts at BOTTOM
// RULE11: Phase correct compare at TOP acts at TOP
// RULE12: Control bits 3 and 2 read zero
// RULE13: Three-bit mode; codes 4 and 6 reserved
// RULE14: Normal TOP MAX, clear-on-match TOP A, immediate
// RULE15: Phase correct: buffered at TOP, flag at BOTTOM
// RULE16: Fast PWM: buffered at BOTTOM, flag MAX or TOP
// RULE17: MAX is 0xFF, BOTTOM is 0x00
// RULE18: Code meaning chosen by current waveform mode
// RULE19: Phase correct counts up then down, TOP once
// RULE20: Fast PWM clears to BOTTOM after TOP
// RULE21: Outputs are reset flip-flops changed by events
package timer_wave_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'h30;
  localparam logic [7:0] ADDR_CTRL_B = 8'h34;
  localparam logic [7:0] ADDR_CMP_A = 8'h38;
  localparam logic [7:0] ADDR_CMP_B = 8'h3c;
  localparam logic [7:0] ADDR_COUNT = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int MODE_LOW_LSB = 0;
  localparam int MODE_HIGH_POS = 3;
  localparam int OVF_POS = 0;
  localparam int OCF_A_POS = 1;
  localparam int OCF_B_POS = 2;
  localparam int DOWN_POS = 3;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  // ****************************************
  // Counter limits, modes and output actions
  // ****************************************
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PHASE_FF = 3'h1;
  localparam logic [2:0] MODE_CLEAR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PHASE_A = 3'h5;
  localparam logic [2:0] MODE_FAST_A = 3'h7;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
endpackage

//--- port_pin_model.sv
// Behavioural port pin with direction bit and internal pull-up.
// Assumes the block's wave output and connect flag as inputs.
`timescale 1ns/1ps
module port_pin_model (
  input wire logic wave,
  input wire logic connect,
  input wire logic dir_out,
  input wire logic port_level,
  output logic pin
);
  // ****************************************
  // Pin level
  // ****************************************
  // Driver off: pull-up holds the pin high
  always_comb
  begin
    if (dir_out)
    begin
      pin = connect ? wave : port_level;
    end
    else
    begin
      pin = 1'b1;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the timer waveform output block.
// Assumes the APB slave answers with pready; the pin model sits on both outputs.
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, psel, penable, pwrite, timer_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rd_err, wave_out_a, wave_out_b, out_a_connect, out_b_connect;
  logic dir_a, dir_b, port_a, port_b, pin_a, pin_b, v;
  int n_errors, n_tests, cyc;
  // ****************************************
  // Instances and clock
  // ****************************************
  timer_wave_output_control dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .timer_tick(timer_tick),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .out_a_connect(out_a_connect), .out_b_connect(out_b_connect));
  port_pin_model pin_a_u (.wave(wave_out_a), .connect(out_a_connect), .dir_out(dir_a),
    .port_level(port_a), .pin(pin_a));
  port_pin_model pin_b_u (.wave(wave_out_b), .connect(out_b_connect), .dir_out(dir_b),
    .port_level(port_b), .pin(pin_b));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // Waits for pready; only the bench timeout ends a wait that never sees it
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] m, input logic [3:0] com, input logic [7:0] a,
    input logic [7:0] b);
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_B, {4'h0, m[2], 3'h0});
    apb(1'b1, timer_wave_pkg::ADDR_CMP_A, a);
    apb(1'b1, timer_wave_pkg::ADDR_CMP_B, b);
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, {com, 2'h0, m[1:0]});
    repeat (600) @(posedge clk);
  endtask
  // Counts high cycles of one output over n cycles
  task automatic meas(input logic sel_b, input int n, input int exp_hi, input string msg);
    int h;
    h = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if ((sel_b ? wave_out_b : wave_out_a) === 1'b1)
        h++;
    end
    chk(h == exp_hi, msg);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    apb(1'b0, timer_wave_pkg::ADDR_CTRL_A, 8'h00);
    chk(rd === 32'h00000000, "control reset value");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'hff);
    apb(1'b0, timer_wave_pkg::ADDR_CTRL_A, 8'h00);
    chk(rd === 32'h000000f3, "reserved control bits");
    apb(1'b0, 8'h48, 8'h00);
    chk(rd_err === 1'b1 && rd === 32'h00000000, "unmapped read");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'h00);
  endtask
  task automatic t_normal();
    cfg(3'h0, 4'h4, 8'h10, 8'h20);
    chk(out_a_connect === 1'b1 && out_b_connect === 1'b0, "connect flags");
    #1;
    v = wave_out_a;
    repeat (256) @(posedge clk);
    #1;
    chk(wave_out_a === ~v, "toggle on match");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'h30);
    repeat (300) @(posedge clk);
    chk(wave_out_b === 1'b1, "set on match");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'h20);
    repeat (300) @(posedge clk);
    chk(wave_out_b === 1'b0 && pin_b === 1'b1, "clear on match, pin off");
    dir_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pin_b === 1'b0, "pin follows wave");
    apb(1'b1, timer_wave_pkg::ADDR_STATUS, 8'h07);
    repeat (300) @(posedge clk);
    apb(1'b0, timer_wave_pkg::ADDR_STATUS, 8'h00);
    chk(rd[0] === 1'b1, "overflow flag at max");
  endtask
  task automatic t_fast();
    cfg(3'h3, 4'h8, 8'h40, 8'h80);
    meas(1'b0, 256, 65, "fast non-inverting");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'hc3);
    repeat (300) @(posedge clk);
    meas(1'b0, 256, 191, "fast inverting");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'h93);
    meas(1'b1, 256, 0, "reserved B code");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'ha3);
    repeat (300) @(posedge clk);
    meas(1'b1, 256, 129, "fast B non-inverting");
  endtask
  task automatic t_phase();
    cfg(3'h1, 4'ha, 8'h40, 8'h40);
    meas(1'b0, 510, 128, "phase A non-inverting");
    meas(1'b1, 510, 128, "phase B non-inverting");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'hf1);
    repeat (600) @(posedge clk);
    meas(1'b0, 510, 382, "phase A inverting");
    meas(1'b1, 510, 382, "phase B inverting");
  endtask
  task automatic t_top();
    cfg(3'h7, 4'ha, 8'h20, 8'h10);
    meas(1'b0, 132, 132, "fast compare at top");
    meas(1'b1, 132, 68, "fast B with top from A");
    cfg(3'h7, 4'h4, 8'h20, 8'h10);
    meas(1'b0, 66, 33, "toggle with high mode bit");
    cfg(3'h5, 4'h8, 8'h20, 8'h10);
    meas(1'b0, 128, 128, "phase compare at top");
    apb(1'b1, timer_wave_pkg::ADDR_CTRL_A, 8'hc1);
    repeat (200) @(posedge clk);
    meas(1'b0, 128, 0, "phase compare at top, inverting");
  endtask
  task automatic t_reserved();
    logic [31:0] c0;
    cfg(3'h4, 4'ha, 8'h20, 8'h10);
    apb(1'b0, timer_wave_pkg::ADDR_COUNT, 8'h00);
    c0 = rd;
    repeat (40) @(posedge clk);
    apb(1'b0, timer_wave_pkg::ADDR_COUNT, 8'h00);
    chk(rd === c0, "reserved mode stops counter");
  endtask
  task automatic t_tick();
    logic [31:0] c0;
    cfg(3'h3, 4'h8, 8'h40, 8'h80);
    timer_tick <= 1'b0;
    apb(1'b0, timer_wave_pkg::ADDR_COUNT, 8'h00);
    c0 = rd;
    v = wave_out_a;
    repeat (300) @(posedge clk);
    apb(1'b0, timer_wave_pkg::ADDR_COUNT, 8'h00);
    chk(rd === c0 && wave_out_a === v, "no tick, no change");
    timer_tick <= 1'b1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    timer_tick = 1'b1;
    dir_a = 1'b1;
    dir_b = 1'b0;
    port_a = 1'b0;
    port_b = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(wave_out_a === 1'b0 && wave_out_b === 1'b0, "outputs after reset");
    chk(pin_a === 1'b0, "pin shows port level");
    t_regs();
    t_normal();
    t_fast();
    t_phase();
    t_top();
    t_reserved();
    t_tick();
    give_verdict();
  end
endmodule
